//--- core/frr_freq_ref_ramp.sv
`timescale 1ns/1ns
module frr_freq_ref_ramp #(
    parameter int CYC_PER_TIME_LSB = frr_pkg::CYC_PER_TIME_LSB
) (
    input  wire logic                            mclk,                  // Control clock.
    input  wire logic                            rst,                   // Sync reset.
    input  wire logic                            ce,                    // Clock enable.
    input  wire logic [frr_pkg::FREQ_W-1:0]      freqCmd,               // Command, 0.01 Hz.
    input  wire logic                            runCmd,                // Run pin.
    input  wire logic                            jogCmd,                // Jog pin.
    input  wire logic                            pairSelEn,             // Select pin valid.
    input  wire logic [1:0]                      pairSel,               // Select pins.
    input  wire logic [frr_pkg::FREQ_W-1:0]      maxOperationFreq,      // Ramp span.
    input  wire logic [frr_pkg::FREQ_W-1:0]      minOutputFreqMotorOne, // Minimum output.
    input  wire logic [frr_pkg::FREQ_W-1:0]      outputFreqUpperLimit,  // Upper limit.
    input  wire logic [frr_pkg::FREQ_W-1:0]      outputFreqLowerLimit,  // Lower limit.
    input  wire logic                            rampTimeUnitSelect,    // 1 = long range.
    input  wire logic                            optimalRampMode,       // Auto ramp.
    input  wire logic                            stallHold,             // Stretch ramp.
    input  wire logic [frr_pkg::FREQ_W-1:0]      slipCompensationTrim,  // Added on top.
    input  wire logic [3:0][frr_pkg::TIME_W-1:0] accelTimes,            // Accel per pair.
    input  wire logic [3:0][frr_pkg::TIME_W-1:0] decelTimes,            // Decel per pair.
    input  wire logic [frr_pkg::FREQ_W-1:0]      jogTargetFreq,         // Jog frequency.
    input  wire logic [frr_pkg::TIME_W-1:0]      jogAccelTime,          // Jog accel time.
    input  wire logic [frr_pkg::TIME_W-1:0]      jogDecelTime,          // Jog decel time.
    input  wire logic [frr_pkg::FREQ_W-1:0]      pairOneFourSwitchFreq, // Pair switch.
    input  wire logic [frr_pkg::TIME_W-1:0]      scurveAccelBegin,      // Segment time.
    input  wire logic [frr_pkg::TIME_W-1:0]      scurveAccelArrival,    // Segment time.
    input  wire logic [frr_pkg::TIME_W-1:0]      scurveDecelBegin,      // Segment time.
    input  wire logic [frr_pkg::TIME_W-1:0]      scurveDecelArrival,    // Segment time.
    input  wire logic [5:0][frr_pkg::FREQ_W-1:0] skipBounds,            // Band bounds.
    output logic      [frr_pkg::FREQ_W-1:0]      freqRef,               // Output reference.
    output logic                                 running,               // Normal run.
    output logic                                 jogging,               // Jog run.
    output logic                                 atTarget,              // Ramp settled.
    output logic      [1:0]                      pairActive             // Time pair in use.
);
    import frr_pkg::*;

    // ****************************************************************
    // State.
    // ****************************************************************
    typedef struct packed {
        frr_mode_t         mode;
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic [SYNC_W-1:0] s3;
        logic [SYNC_W-1:0] pins;
        logic [FREQ_W-1:0] outFreq;
        logic [DEN_W-1:0]  acc;
        logic [FREQ_W-1:0] freqRef;
        logic              running;
        logic              jogging;
        logic              atTarget;
        logic [1:0]        pairActive;
    } frr_state_t;

    frr_state_t q;
    frr_state_t d;

    frr_ramp_if rif ();

    logic              runS;
    logic              jogS;
    logic [FREQ_W-1:0] rampTarget;
    logic [FREQ_W-1:0] spanFreq;
    logic [DEN_W-1:0]  denNow;
    logic [DEN_W:0]    stepAcc;
    logic [FREQ_W:0]   trimSum;
    logic              cutNow;
    logic              doRamp;

    assign runS = q.pins[4];
    assign jogS = q.pins[3];

    assign rif.outFreq = q.outFreq;
    assign rif.jogMode = q.mode == MODE_JOG;

    // ****************************************************************
    // Target conditioning and ramp times.
    // ****************************************************************
    frr_cond u_cond (
        .freqCmd               (freqCmd),
        .minOutputFreqMotorOne (minOutputFreqMotorOne),
        .outputFreqLowerLimit  (outputFreqLowerLimit),
        .outputFreqUpperLimit  (outputFreqUpperLimit),
        .skipBounds            (skipBounds),
        .rif                   (rif.cond)
    );

    frr_time #(
        .CYC_PER_TIME_LSB (CYC_PER_TIME_LSB)
    ) u_time (
        .accelTimes            (accelTimes),
        .decelTimes            (decelTimes),
        .jogAccelTime          (jogAccelTime),
        .jogDecelTime          (jogDecelTime),
        .scurveAccelBegin      (scurveAccelBegin),
        .scurveAccelArrival    (scurveAccelArrival),
        .scurveDecelBegin      (scurveDecelBegin),
        .scurveDecelArrival    (scurveDecelArrival),
        .rampTimeUnitSelect    (rampTimeUnitSelect),
        .pairOneFourSwitchFreq (pairOneFourSwitchFreq),
        .pairSelEn             (q.pins[2]),
        .pairSel               (q.pins[1:0]),
        .rif                   (rif.timing)
    );

    // ****************************************************************
    // Next state.
    // ****************************************************************
    always_comb begin
        d = q;
        if (q.mode == MODE_JOG) begin
            rampTarget = jogS ? jogTargetFreq : FREQ_ZERO;
            spanFreq   = jogTargetFreq;
        end else begin
            rampTarget = (runS && !rif.inactive) ? rif.target : FREQ_ZERO;
            spanFreq   = maxOperationFreq;
        end
        if (optimalRampMode) begin
            denNow = DEN_W'(spanFreq);
        end else begin
            denNow = (rampTarget > q.outFreq) ? rif.accelDen : rif.decelDen;
        end
        stepAcc = {1'b0, q.acc} + (DEN_W+1)'(spanFreq);
        cutNow  = q.mode == MODE_RUN && rampTarget == FREQ_ZERO &&
                  q.outFreq <= minOutputFreqMotorOne;
        doRamp  = 1'b0;
        trimSum = '0;
        if (ce) begin
            d.s1 = {runCmd, jogCmd, pairSelEn, pairSel};
            d.s2 = q.s1;
            d.s3 = q.s2;
            if (q.s2 == q.s3) begin
                d.pins = q.s3;
            end
            case (q.mode)
                MODE_IDLE: begin
                    d.outFreq = FREQ_ZERO;
                    d.acc     = '0;
                    if (jogS) begin
                        d.mode = MODE_JOG;
                    end else if (runS && !rif.inactive) begin
                        d.mode    = MODE_RUN;
                        d.outFreq = minOutputFreqMotorOne;
                    end
                end
                MODE_RUN: begin
                    if (cutNow) begin
                        d.mode    = MODE_IDLE;
                        d.outFreq = FREQ_ZERO;
                        d.acc     = '0;
                    end else begin
                        doRamp = 1'b1;
                    end
                end
                MODE_JOG: begin
                    if (!jogS && q.outFreq == FREQ_ZERO) begin
                        d.mode = MODE_IDLE;
                        d.acc  = '0;
                    end else begin
                        doRamp = 1'b1;
                    end
                end
                default: begin
                    d.mode = MODE_IDLE;
                end
            endcase
            // The output walks through skip bands; only the steady target avoids them.
            if (doRamp && q.outFreq == rampTarget) begin
                d.acc = '0;
            end else if (doRamp && !stallHold) begin
                if (denNow == '0) begin
                    d.outFreq = rampTarget;
                    d.acc     = '0;
                end else if (stepAcc >= {1'b0, denNow}) begin
                    d.acc     = DEN_W'(stepAcc - {1'b0, denNow});
                    d.outFreq = (rampTarget > q.outFreq) ? q.outFreq + 16'h0001
                                                         : q.outFreq - 16'h0001;
                end else begin
                    d.acc = DEN_W'(stepAcc);
                end
            end
            trimSum = {1'b0, d.outFreq} + {1'b0, slipCompensationTrim};
            if (d.mode == MODE_IDLE) begin
                d.freqRef = FREQ_ZERO;
            end else if (trimSum > {1'b0, rif.upperEff}) begin
                d.freqRef = rif.upperEff;
            end else begin
                d.freqRef = FREQ_W'(trimSum);
            end
            d.running    = d.mode == MODE_RUN;
            d.jogging    = d.mode == MODE_JOG;
            d.atTarget   = d.mode != MODE_IDLE && d.outFreq == rampTarget;
            d.pairActive = rif.pairIdx;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign freqRef    = q.freqRef;
    assign running    = q.running;
    assign jogging    = q.jogging;
    assign atTarget   = q.atTarget;
    assign pairActive = q.pairActive;

    // ****************************************************************
    // Checks.
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence sIdleStart;
        ce && q.mode == MODE_IDLE && runS && !jogS && !rif.inactive;
    endsequence

    sequence sCutAtMin;
        ce && cutNow;
    endsequence

    property pStartAtMin;
        sIdleStart |=> q.mode == MODE_RUN && q.outFreq == $past(minOutputFreqMotorOne);
    endproperty

    property pCutHolds;
        sCutAtMin ##1 (!ce || rif.inactive || !runS) |=> q.freqRef == FREQ_ZERO;
    endproperty

    a_upper_cap: assert property (
        ce |=> q.freqRef <= $past(rif.upperEff))
        else $error("Output reference above upper limit.");

    a_ready_idle: assert property (
        ce && q.mode == MODE_IDLE && rif.inactive && !jogS |=>
            q.mode == MODE_IDLE && q.freqRef == FREQ_ZERO)
        else $error("Drive left ready state below minimum.");

    a_start_min: assert property (pStartAtMin)
        else $error("Start did not begin at minimum frequency.");

    a_cut_min: assert property (sCutAtMin |=> q.mode == MODE_IDLE &&
                                q.outFreq == FREQ_ZERO)
        else $error("Output not cut at minimum during stop.");

    a_cut_stays: assert property (pCutHolds)
        else $error("Output reappeared after cut.");

    a_jog_refused: assert property (
        ce && q.mode == MODE_RUN |=> q.mode != MODE_JOG)
        else $error("Jog accepted while running.");

    a_jog_exclusive: assert property (
        q.mode == MODE_JOG |=> q.mode != MODE_RUN)
        else $error("Run accepted during jog.");

    a_stall_hold: assert property (
        ce && stallHold && doRamp |=> q.outFreq == $past(q.outFreq))
        else $error("Ramp moved while stretched.");

    a_ramp_step: assert property (
        ce && doRamp && denNow != '0 |=>
            (q.outFreq <= $past(q.outFreq) + 1) && (q.outFreq + 1 >= $past(q.outFreq)))
        else $error("Ramp stepped by more than one count.");

    a_lower_clamp: assert property (
        !rif.inactive && outputFreqLowerLimit <= rif.upperEff |->
            rif.target >= outputFreqLowerLimit)
        else $error("Target below lower limit.");

    a_pair_default: assert property (
        !q.pins[2] && pairOneFourSwitchFreq == FREQ_ZERO |-> rif.pairIdx == PAIR_ONE)
        else $error("Default time pair not selected.");

endmodule // frr_freq_ref_ramp

//--- core/frr_pkg.sv
// Notes on behaviour
// - Command above upper limit runs at limit.
// - Command between minimum and lower limit runs lower.
// - Command below minimum: ready, no output.
// - Trimmed output still capped at upper limit.
// - Start at minimum frequency, ignoring lower limit.
// - Accel time spans zero to maximum frequency.
// - Decel time spans maximum frequency to zero.
// - Unit select picks short or long range.
// - Optimal mode ignores programmed ramp times.
// - Four time pairs by inputs, pair one default.
// - Stall or torque limit may stretch ramps.
// - Jog ramps to jog frequency and back.
// - Jog refused while running; jog blocks run.
// - Threshold swaps pairs one/four; inputs win.
// - S-curve off when ramp time is zero.
// - Effective time adds half the segment sum.
// - Segment times clamped per unit range.
// - Zero skip bounds disable that band.
// - Three bands keep steady output outside.
// - Ramps pass through skip bands continuously.
// - Run-mode deceleration cuts output at minimum frequency.
package frr_pkg;

    localparam int FREQ_W    = 16;
    localparam int TIME_W    = 20;
    localparam int DEN_W     = 40;
    localparam int NUM_PAIRS = 4;
    localparam int NUM_BANDS = 3;
    localparam int SYNC_W    = 5;

    localparam logic [FREQ_W-1:0] FREQ_LIMIT = 16'hea60;
    localparam logic [FREQ_W-1:0] FREQ_ZERO  = 16'h0000;

    localparam logic [TIME_W-1:0] RAMP_MAX_SHORT   = 20'h0ea60;
    localparam logic [TIME_W-1:0] RAMP_MAX_LONG    = 20'h927c0;
    localparam logic [TIME_W-1:0] SCURVE_MAX_SHORT = 20'h009c4;
    localparam logic [TIME_W-1:0] SCURVE_MAX_LONG  = 20'h061a8;

    localparam int CLK_PERIOD_NS    = 50;
    localparam int TIME_LSB_NS      = 10000000;
    localparam int CYC_PER_TIME_LSB = TIME_LSB_NS / CLK_PERIOD_NS;

    localparam logic [1:0] PAIR_ONE  = 2'h0;
    localparam logic [1:0] PAIR_FOUR = 2'h3;

    typedef enum logic [1:0] {MODE_IDLE, MODE_RUN, MODE_JOG} frr_mode_t;

    function automatic logic [TIME_W-1:0] clampTime(input logic [TIME_W-1:0] t,
                                                    input logic [TIME_W-1:0] lim);
        return (t > lim) ? lim : t;
    endfunction

    function automatic logic [TIME_W:0] effTime(input logic [TIME_W-1:0] t,
                                                input logic [TIME_W-1:0] b,
                                                input logic [TIME_W-1:0] a);
        logic [TIME_W-1:0] bc;
        logic [TIME_W-1:0] ac;
        logic [TIME_W:0]   half;
        bc   = (b > t) ? t : b;
        ac   = (a > t) ? t : a;
        half = (21'(bc) + 21'(ac)) >> 1;
        if (t == '0) begin
            return '0;
        end
        return 21'(t) + half;
    endfunction

endpackage

//--- core/frr_ramp_if.sv
`timescale 1ns/1ns
interface frr_ramp_if;
    logic [frr_pkg::FREQ_W-1:0] target;
    logic                       inactive;
    logic [frr_pkg::FREQ_W-1:0] upperEff;
    logic [frr_pkg::FREQ_W-1:0] outFreq;
    logic                       jogMode;
    logic [frr_pkg::DEN_W-1:0]  accelDen;
    logic [frr_pkg::DEN_W-1:0]  decelDen;
    logic [1:0]                 pairIdx;

    modport core   (input target, inactive, upperEff, accelDen, decelDen, pairIdx,
                    output outFreq, jogMode);
    modport cond   (output target, inactive, upperEff);
    modport timing (input outFreq, jogMode, output accelDen, decelDen, pairIdx);
endinterface

//--- core/frr_cond.sv
`timescale 1ns/1ns
module frr_cond (
    input  wire logic [frr_pkg::FREQ_W-1:0]      freqCmd,              // Frequency command.
    input  wire logic [frr_pkg::FREQ_W-1:0]      minOutputFreqMotorOne, // Minimum output.
    input  wire logic [frr_pkg::FREQ_W-1:0]      outputFreqLowerLimit, // Lower limit.
    input  wire logic [frr_pkg::FREQ_W-1:0]      outputFreqUpperLimit, // Upper limit.
    input  wire logic [5:0][frr_pkg::FREQ_W-1:0] skipBounds,           // Band bounds.
    frr_ramp_if.cond                              rif                   // Target side.
);
    import frr_pkg::*;

    logic [FREQ_W-1:0] steered;
    logic [FREQ_W-1:0] upperCap;
    logic [FREQ_W-1:0] clamped;

    always_comb begin
        steered = freqCmd;
        for (int i = 0; i < NUM_BANDS; i++) begin
            if ((skipBounds[2*i] != FREQ_ZERO || skipBounds[2*i+1] != FREQ_ZERO) &&
                freqCmd > skipBounds[2*i+1] && freqCmd < skipBounds[2*i]) begin
                steered = skipBounds[2*i+1];
            end
        end
        upperCap = (outputFreqUpperLimit > FREQ_LIMIT) ? FREQ_LIMIT : outputFreqUpperLimit;
        clamped  = steered;
        if (clamped < outputFreqLowerLimit) begin
            clamped = outputFreqLowerLimit;
        end
        if (clamped > upperCap) begin
            clamped = upperCap;
        end
        rif.inactive = freqCmd < minOutputFreqMotorOne;
        rif.target   = rif.inactive ? FREQ_ZERO : clamped;
        rif.upperEff = upperCap;
    end

endmodule // frr_cond

//--- core/frr_time.sv
`timescale 1ns/1ns
module frr_time #(
    parameter int CYC_PER_TIME_LSB = frr_pkg::CYC_PER_TIME_LSB
) (
    input  wire logic [3:0][frr_pkg::TIME_W-1:0] accelTimes,            // Accel per pair.
    input  wire logic [3:0][frr_pkg::TIME_W-1:0] decelTimes,            // Decel per pair.
    input  wire logic [frr_pkg::TIME_W-1:0]      jogAccelTime,          // Jog accel time.
    input  wire logic [frr_pkg::TIME_W-1:0]      jogDecelTime,          // Jog decel time.
    input  wire logic [frr_pkg::TIME_W-1:0]      scurveAccelBegin,      // Segment time.
    input  wire logic [frr_pkg::TIME_W-1:0]      scurveAccelArrival,    // Segment time.
    input  wire logic [frr_pkg::TIME_W-1:0]      scurveDecelBegin,      // Segment time.
    input  wire logic [frr_pkg::TIME_W-1:0]      scurveDecelArrival,    // Segment time.
    input  wire logic                            rampTimeUnitSelect,    // 1 = long range.
    input  wire logic [frr_pkg::FREQ_W-1:0]      pairOneFourSwitchFreq, // Pair switch.
    input  wire logic                            pairSelEn,             // Select in force.
    input  wire logic [1:0]                      pairSel,               // Selected pair.
    frr_ramp_if.timing                            rif                    // Ramp side.
);
    import frr_pkg::*;

    logic [TIME_W-1:0] rampMax;
    logic [TIME_W-1:0] segMax;
    logic [TIME_W-1:0] ta;
    logic [TIME_W-1:0] td;
    logic [1:0]        pair;

    always_comb begin
        rampMax = rampTimeUnitSelect ? RAMP_MAX_LONG : RAMP_MAX_SHORT;
        segMax  = rampTimeUnitSelect ? SCURVE_MAX_LONG : SCURVE_MAX_SHORT;
        if (pairSelEn) begin
            pair = pairSel;
        end else if (pairOneFourSwitchFreq != FREQ_ZERO &&
                     rif.outFreq >= pairOneFourSwitchFreq) begin
            pair = PAIR_FOUR;
        end else begin
            pair = PAIR_ONE;
        end
        ta = clampTime(rif.jogMode ? jogAccelTime : accelTimes[pair], rampMax);
        td = clampTime(rif.jogMode ? jogDecelTime : decelTimes[pair], rampMax);
        // Segment rounding is folded into the slope as a stretch of the ramp.
        rif.accelDen = DEN_W'(effTime(ta, clampTime(scurveAccelBegin, segMax),
                                      clampTime(scurveAccelArrival, segMax))) *
                       DEN_W'(CYC_PER_TIME_LSB);
        rif.decelDen = DEN_W'(effTime(td, clampTime(scurveDecelBegin, segMax),
                                      clampTime(scurveDecelArrival, segMax))) *
                       DEN_W'(CYC_PER_TIME_LSB);
        rif.pairIdx  = pair;
    end

endmodule // frr_time

//--- dv/frr_mod_model.sv
`timescale 1ns/1ns
// ************************************************************
// Modulation stage model: feeds back a slip trim on request.
// ************************************************************
module frr_mod_model (
    input wire logic                  mclk,     // Control clock.
    input wire logic [frr_pkg::FREQ_W-1:0] freqRef, // Reference taken in.
    input wire logic                  trimEn,   // Trim request.
    output logic [frr_pkg::FREQ_W-1:0] slipTrim // Trim fed back.
);
    import frr_pkg::*;
    always_ff @(posedge mclk) begin
        // Slip trim only appears while the drive is producing an output.
        slipTrim <= (trimEn && freqRef != FREQ_ZERO) ? 16'h001e : FREQ_ZERO;
    end
endmodule // frr_mod_model

//--- dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import frr_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, runCmd = 1'b0, jogCmd = 1'b0, pairSelEn = 1'b0;
    logic optimalRampMode = 1'b0, stallHold = 1'b0, trimEn = 1'b0, ce = 1'b1;
    logic [1:0] pairSel = 2'h0;
    logic rampTimeUnitSelect = 1'b0;
    logic [1:0] pairActive;
    logic running, jogging, atTarget;
    logic [FREQ_W-1:0] freqCmd = 16'h0000, outputFreqLowerLimit = 16'h0000;
    logic [FREQ_W-1:0] maxOperationFreq = 16'h000a, minOutputFreqMotorOne = 16'h0014;
    logic [FREQ_W-1:0] outputFreqUpperLimit = 16'h003c, jogTargetFreq = 16'h001e;
    logic [FREQ_W-1:0] pairOneFourSwitchFreq = 16'h0000, slipCompensationTrim, freqRef;
    logic [TIME_W-1:0] scurveAccelBegin = 20'h00000, jogAccelTime = 20'h0000a;
    logic [3:0][TIME_W-1:0] accelTimes = {4{20'h0000a}}, decelTimes = {4{20'h0000a}};
    logic [5:0][FREQ_W-1:0] skipBounds = '0;
    int nFail = 0;
    int numChecks = 0;
    frr_freq_ref_ramp #(.CYC_PER_TIME_LSB(2)) dut (.mclk, .rst, .ce, .freqCmd, .runCmd,
        .jogCmd, .pairSelEn, .pairSel, .maxOperationFreq, .minOutputFreqMotorOne,
        .outputFreqUpperLimit, .outputFreqLowerLimit, .rampTimeUnitSelect,
        .optimalRampMode, .stallHold, .slipCompensationTrim, .accelTimes, .decelTimes,
        .jogTargetFreq, .jogAccelTime, .jogDecelTime(jogAccelTime), .pairOneFourSwitchFreq,
        .scurveAccelBegin, .scurveAccelArrival(scurveAccelBegin), .scurveDecelBegin(20'h0),
        .scurveDecelArrival(20'h0), .skipBounds, .freqRef, .running, .jogging, .atTarget,
        .pairActive);
    frr_mod_model partner (.mclk, .freqRef, .trimEn, .slipTrim(slipCompensationTrim));
    always #25 mclk = ~mclk;
    // ************************************************************
    // Compare and wait helpers.
    // ************************************************************
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        numChecks++;
        if (seen !== exp) begin
            nFail++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, seen);
        end
    endtask
    task automatic chkIn(input string what, input int lo, input int hi, input int seen);
        numChecks++;
        if (seen < lo || seen > hi) begin
            nFail++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask
    function automatic logic bitOf(input int k);
        return (k == 0) ? running : (k == 1) ? jogging : atTarget;
    endfunction
    task automatic waitBit(input int k, input logic v, input int lim, output int n);
        n = 0;
        @(negedge mclk);
        while (bitOf(k) !== v && n < lim) begin
            @(negedge mclk);
            n++;
        end
        if (bitOf(k) !== v) begin
            nFail++;
            $display("MISMATCH wait%0d expected %0d seen %0d", k, v, bitOf(k));
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic stopRun(input int lo, input int hi);
        int n;
        @(posedge mclk);
        runCmd <= 1'b0;
        waitBit(0, 1'b0, 300, n);
        chkIn("decelCycles", lo, hi, n);
        chk("stopFreq", 16'h0000, freqRef);
        @(posedge mclk);
    endtask
    task automatic runTo(input logic [15:0] cmd, input logic [15:0] exp);
        int n;
        @(posedge mclk);
        freqCmd <= cmd;
        runCmd <= 1'b1;
        waitBit(2, 1'b1, 600, n);
        chk("target", exp, freqRef);
        stopRun(0, 300);
    endtask
    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic tBelowMin;
        @(posedge mclk);
        freqCmd <= 16'h000a;
        runCmd <= 1'b1;
        tick(12);
        chk("readyRun", 16'h0000, {15'h0, running});
        chk("readyFreq", 16'h0000, freqRef);
        @(posedge mclk);
        runCmd <= 1'b0;
        tick(6);
    endtask
    task automatic tRamp(input logic [19:0] seg, input int lo, input int hi);
        int n;
        @(posedge mclk);
        scurveAccelBegin <= seg;
        outputFreqLowerLimit <= 16'h001e;
        freqCmd <= 16'h0050;
        runCmd <= 1'b1;
        waitBit(0, 1'b1, 20, n);
        chk("startFreq", 16'h0014, freqRef);
        waitBit(2, 1'b1, 600, n);
        chkIn("accelCycles", lo, hi, n);
        stopRun(78, 92);
        outputFreqLowerLimit <= 16'h0000;
    endtask
    task automatic tOptimal;
        int n;
        logic [15:0] f;
        @(posedge mclk);
        optimalRampMode <= 1'b1;
        freqCmd <= 16'h0050;
        runCmd <= 1'b1;
        waitBit(0, 1'b1, 20, n);
        @(posedge mclk);
        stallHold <= 1'b1;
        tick(2);
        f = freqRef;
        tick(20);
        chk("stallFreq", f, freqRef);
        @(posedge mclk);
        stallHold <= 1'b0;
        waitBit(2, 1'b1, 300, n);
        chkIn("optCycles", 60 - f - 2, 60 - f + 4, n);
        @(posedge mclk);
        trimEn <= 1'b1;
        tick(4);
        chk("trimCap", 16'h003c, freqRef);
        @(posedge mclk);
        trimEn <= 1'b0;
        jogCmd <= 1'b1;
        tick(10);
        chk("jogRefused", 16'h0000, {15'h0, jogging});
        @(posedge mclk);
        jogCmd <= 1'b0;
        pairSelEn <= 1'b1;
        pairOneFourSwitchFreq <= 16'h0032;
        for (int k = 0; k < 4; k++) begin
            pairSel <= 2'(k);
            tick(7);
            chk("pairExt", 16'(k), {14'h0, pairActive});
            @(posedge mclk);
        end
        pairSelEn <= 1'b0;
        tick(7);
        chk("pairThresh", 16'h0003, {14'h0, pairActive});
        @(posedge mclk);
        pairOneFourSwitchFreq <= 16'h0000;
        optimalRampMode <= 1'b0;
        tick(7);
        chk("pairDefault", 16'h0000, {14'h0, pairActive});
        stopRun(0, 300);
    endtask
    task automatic tLong;
        int n;
        @(posedge mclk);
        rampTimeUnitSelect <= 1'b1;
        maxOperationFreq <= 16'hea60;
        accelTimes <= {4{20'hfffff}};
        freqCmd <= 16'h0050;
        runCmd <= 1'b1;
        waitBit(0, 1'b1, 20, n);
        waitBit(2, 1'b1, 900, n);
        chkIn("longCycles", 790, 810, n);
        stopRun(30, 50);
        rampTimeUnitSelect <= 1'b0;
        maxOperationFreq <= 16'h000a;
        accelTimes <= {4{20'h0000a}};
    endtask
    task automatic tJog;
        int n;
        @(posedge mclk);
        jogCmd <= 1'b1;
        waitBit(1, 1'b1, 20, n);
        @(posedge mclk);
        runCmd <= 1'b1;
        waitBit(2, 1'b1, 400, n);
        chk("jogFreq", 16'h001e, freqRef);
        chk("runIgnored", 16'h0000, {15'h0, running});
        @(posedge mclk);
        runCmd <= 1'b0;
        tick(6);
        @(posedge mclk);
        jogCmd <= 1'b0;
        waitBit(1, 1'b0, 400, n);
        chk("jogEnd", 16'h0000, freqRef);
    endtask
    task automatic wrapUp;
        $display("checks %0d mismatches %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        nFail++;
        wrapUp();
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        tick(1);
        chk("resetFreq", 16'h0000, freqRef);
        tBelowMin();
        tRamp(20'h00000, 76, 86);
        tRamp(20'h0000a, 156, 168);
        runTo(16'h0050, 16'h003c);
        outputFreqLowerLimit <= 16'h0028;
        runTo(16'h001e, 16'h0028);
        outputFreqLowerLimit <= 16'h0000;
        skipBounds <= {16'h0, 16'h0, 16'h002d, 16'h003a, 16'h0041, 16'h0046};
        runTo(16'h0032, 16'h002d);
        skipBounds <= '0;
        runTo(16'h0032, 16'h0032);
        tLong();
        tOptimal();
        tJog();
        wrapUp();
    end
endmodule // tb_top
